// ==== hdl/sfe_flash_end.sv ====
/*
 Flash end: front end of a 64 Mbit serial flash; pin logic on the serial
 clock, bytes cross to clk_in. Assumes the host end on sfe_if.
*/
// What this block does
// (RULE_01) Select, clock, data in, data out
// (RULE_02) Works with clock idling low or high
// (RULE_03) Sample on rising, shift out on falling
// (RULE_04) Dual commands use lanes zero and one
// (RULE_05) Quad commands use four lanes
// (RULE_06) Quad commands only with enable bit set
// (RULE_07) Pause only while enable bit clear
// (RULE_08) Pause never stops internal operations
// (RULE_09) Pause starts on low pin, clock low
// (RULE_10) Pause ends on high pin, clock low
// (RULE_11) Paused: output floats from the next falling clock, inputs ignored
// (RULE_12) Select rising while paused resets interface
// (RULE_13) Host releases pause before selecting again
// (RULE_14) Host always drives select high idle
// (RULE_15) Pages are aligned 256 bytes
// (RULE_16) Sectors 4K, blocks 32K or 64K aligned
// (RULE_17) 24-bit byte address over 8 Mbyte
// (RULE_18) Lane direction chosen per command phase
// (RULE_19) Select high ends the transaction
`timescale 1ns/100ps
`default_nettype none
`include "sfe_consts.svh"
module sfe_flash_end (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    sfe_if.dev               lnk,
    input  wire logic        quad_lane_enable_bit_in,
    input  wire logic        tx_load_in,
    input  wire logic [7:0]  tx_byte_in,
    output logic             sel_out,
    output logic             rx_valid_out,
    output sfe_pkg::sfe_phase_e rx_kind_out,
    output logic [7:0]       rx_byte_out,
    output logic [7:0]       cmd_out,
    output logic [23:0]      addr_out,
    output logic [23:0]      erase_base_out
);
    import sfe_pkg::*;
    sfe_frame_s fr_q;
    sfe_frame_s fr_d;
    sfe_xfer_s  xf_q;
    sfe_xfer_s  xf_d;
    sfe_drive_s dr_q;
    sfe_drive_s dr_d;
    sfe_user_s  us_q;
    sfe_user_s  us_d;
    sfe_cmd_s   dec;
    sfe_width_t w;
    logic [7:0] sh_nx;
    logic [7:0] osh;
    logic [3:0] bits_nx;
    logic [23:0] addr_nx;
    logic       paused;
    logic       done;
    logic       frame_rst_n;

    // (RULE_12) select high clears the interface, paused or not
    // (RULE_19) next select starts from the command byte
    // (RULE_02) no state depends on the clock's idle level
    assign frame_rst_n = rstn_in & ~lnk.cs_n;

    // (RULE_07) pause pin is data when the enable bit is set
    assign paused = ~xf_q.qe2 & ~lnk.lane[3];

    always_comb begin
        fr_d = fr_q;
        xf_d = xf_q;
        xf_d.qe1 = quad_lane_enable_bit_in;
        xf_d.qe2 = xf_q.qe1;
        w = (fr_q.ph == SFE_PH_ADDR) ? fr_q.dec.aw : ((fr_q.ph == SFE_PH_DATA) ? fr_q.dec.dw : `SFE_W1);
        // (RULE_01) single lane input is lane zero
        // (RULE_03) input bits sampled on the rising clock
        sh_nx = sfe_shift_in(fr_q.sh, w, lnk.lane);
        bits_nx = fr_q.bits + {1'b0, w};
        addr_nx = {fr_q.addr[15:0], sh_nx};
        done = (bits_nx == `SFE_BYTE_BITS);
        dec = sfe_decode(sh_nx);
        // (RULE_09) a rising edge seen with the pin low is ignored
        // (RULE_10) pause ends once the clock was low with pin high
        // (RULE_11) clock and inputs ignored while paused
        if (!paused && fr_q.ph != SFE_PH_DROP) begin
            fr_d.sh = sh_nx;
            fr_d.bits = done ? 4'h0 : bits_nx;
            if (done) begin
                xf_d.tgl = ~xf_q.tgl;
                xf_d.dat = sh_nx;
                xf_d.kind = fr_q.ph;
                case (fr_q.ph)
                    SFE_PH_CMD: begin
                        fr_d.dec = dec;
                        xf_d.cmd = sh_nx;
                        // (RULE_06) quad command dropped without enable bit
                        if (dec.quad && !xf_q.qe2) begin
                            fr_d.ph = SFE_PH_DROP;
                        end else if (dec.has_addr) begin
                            fr_d.ph = SFE_PH_ADDR;
                        end else begin
                            fr_d.ph = SFE_PH_DATA;
                        end
                    end
                    SFE_PH_ADDR: begin
                        fr_d.addr = addr_nx;
                        fr_d.acnt = fr_q.acnt + 2'h1;
                        if (fr_q.acnt == `SFE_ADDR_LAST) begin
                            fr_d.ph = SFE_PH_DATA;
                            // (RULE_17) byte address within the array
                            xf_d.addr = addr_nx & `SFE_ARRAY_MASK;
                        end
                    end
                    default: fr_d.ph = fr_q.ph;
                endcase
            end
        end
    end

    always_comb begin
        dr_d = dr_q;
        osh = dr_q.osh;
        if (fr_q.ph == SFE_PH_DATA && fr_q.dec.dev_out) begin
            if (fr_q.bits == 4'h0) begin
                // Word crossing: tx byte is held steady by the user side
                osh = us_q.tx;
            end else begin
                osh = dr_q.osh << fr_q.dec.dw;
            end
        end
        dr_d.oe = 4'h0;
        // (RULE_11) output floats from the first falling clock seen while paused
        // (RULE_18) only data phases of read commands drive
        if (!paused && fr_q.ph == SFE_PH_DATA && fr_q.dec.dev_out) begin
            dr_d.osh = osh;
            // (RULE_03) output bits change on the falling clock
            // (RULE_05) quad data on all four lanes
            if (fr_q.dec.dw == `SFE_W4) begin
                dr_d.lane = osh[7:4];
                dr_d.oe = 4'hf;
            // (RULE_04) dual data on lanes zero and one
            end else if (fr_q.dec.dw == `SFE_W2) begin
                dr_d.lane = {2'h0, osh[7:6]};
                dr_d.oe = 4'h3;
            end else begin
                dr_d.lane = {2'h0, osh[7], 1'b0};
                dr_d.oe = 4'h2;
            end
        end
    end

    always_comb begin
        us_d = us_q;
        us_d.t1 = xf_q.tgl;
        us_d.t2 = us_q.t1;
        us_d.t3 = us_q.t2;
        us_d.c1 = ~lnk.cs_n;
        us_d.c2 = us_q.c1;
        us_d.valid = us_q.t2 ^ us_q.t3;
        // (RULE_08) array side runs on regardless of pause
        if (us_q.t2 ^ us_q.t3) begin
            us_d.dat = xf_q.dat;
            us_d.kind = xf_q.kind;
            us_d.cmd = xf_q.cmd;
            us_d.addr = xf_q.addr;
            // (RULE_16) erase bases on sector and block bounds
            if (xf_q.cmd == `SFE_C_SE) begin
                us_d.base = xf_q.addr & `SFE_SECT_MASK;
            end else if (xf_q.cmd == `SFE_C_BE32) begin
                us_d.base = xf_q.addr & `SFE_B32_MASK;
            end else if (xf_q.cmd == `SFE_C_BE64) begin
                us_d.base = xf_q.addr & `SFE_B64_MASK;
            end else begin
                // (RULE_15) page base for page writes
                us_d.base = xf_q.addr & `SFE_PAGE_MASK;
            end
        end
        if (tx_load_in) begin
            us_d.tx = tx_byte_in;
        end
    end

    always_ff @(posedge lnk.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fr_q <= '0;
        end else begin
            fr_q <= fr_d;
        end
    end

    // Kept across select so a last byte is not lost to the reset above
    always_ff @(posedge lnk.sclk or negedge rstn_in) begin
        if (!rstn_in) begin
            xf_q <= '0;
        end else begin
            xf_q <= xf_d;
        end
    end

    always_ff @(negedge lnk.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            dr_q <= '0;
        end else begin
            dr_q <= dr_d;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            us_q <= '0;
        end else begin
            us_q <= us_d;
        end
    end

    assign lnk.d_d = dr_q.lane;
    assign lnk.d_oe = dr_q.oe;
    assign sel_out = us_q.c2;
    assign rx_valid_out = us_q.valid;
    assign rx_kind_out = us_q.kind;
    assign rx_byte_out = us_q.dat;
    assign cmd_out = us_q.cmd;
    assign addr_out = us_q.addr;
    assign erase_base_out = us_q.base;
endmodule
`default_nettype wire

// ==== include/sfe_consts.svh ====
/*
 Constants of the serial flash front end: address masks, lane widths,
 divider phases and command codes. Assumes inclusion by bare name.
*/
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH
`define SFE_ARRAY_MASK 24'h7fffff
`define SFE_PAGE_MASK  24'hffff00
`define SFE_SECT_MASK  24'hfff000
`define SFE_B32_MASK   24'hff8000
`define SFE_B64_MASK   24'hff0000
`define SFE_W1         3'h1
`define SFE_W2         3'h2
`define SFE_W4         3'h4
`define SFE_BYTE_BITS  4'h8
`define SFE_ADDR_LAST  2'h2
`define SFE_DIV_RISE   3'h3
`define SFE_DIV_FALL   3'h7
`define SFE_C_READ     8'h03
`define SFE_C_FAST     8'h0b
`define SFE_C_PP       8'h02
`define SFE_C_SE       8'h20
`define SFE_C_BE32     8'h52
`define SFE_C_BE64     8'hd8
`define SFE_C_DOR      8'h3b
`define SFE_C_QOR      8'h6b
`define SFE_C_DIO      8'hbb
`define SFE_C_QIO      8'heb
`define SFE_C_QIOW     8'he7
`define SFE_C_DID      8'h92
`define SFE_C_QID      8'h94
`define SFE_C_QPP      8'h32
`define SFE_C_RDSR     8'h05
`define SFE_C_RDID     8'h9f
`endif

// ==== include/sfe_pkg.sv ====
/*
 Types and helper functions shared by both ends of the serial flash link.
 Assumes sfe_consts.svh on the include path.
*/
`include "sfe_consts.svh"
package sfe_pkg;
    typedef logic [2:0] sfe_width_t;
    typedef enum logic [1:0] {
        SFE_PH_CMD  = 2'b00,
        SFE_PH_ADDR = 2'b01,
        SFE_PH_DATA = 2'b11,
        SFE_PH_DROP = 2'b10
    } sfe_phase_e;
    typedef enum logic [2:0] {
        SFE_H_IDLE = 3'b000,
        SFE_H_CMD  = 3'b001,
        SFE_H_ADDR = 3'b011,
        SFE_H_DATA = 3'b010,
        SFE_H_GAP  = 3'b110
    } sfe_host_e;
    typedef struct packed {
        logic       has_addr;
        logic       dev_out;
        logic       quad;
        sfe_width_t aw;
        sfe_width_t dw;
    } sfe_cmd_s;
    typedef struct packed {
        sfe_phase_e  ph;
        logic [3:0]  bits;
        logic [7:0]  sh;
        logic [1:0]  acnt;
        sfe_cmd_s    dec;
        logic [23:0] addr;
    } sfe_frame_s;
    typedef struct packed {
        logic        qe1;
        logic        qe2;
        logic        tgl;
        logic [7:0]  dat;
        sfe_phase_e  kind;
        logic [7:0]  cmd;
        logic [23:0] addr;
    } sfe_xfer_s;
    typedef struct packed {
        logic [7:0] osh;
        logic [3:0] lane;
        logic [3:0] oe;
    } sfe_drive_s;
    typedef struct packed {
        logic        t1;
        logic        t2;
        logic        t3;
        logic        c1;
        logic        c2;
        logic        valid;
        logic [7:0]  dat;
        sfe_phase_e  kind;
        logic [7:0]  cmd;
        logic [23:0] addr;
        logic [23:0] base;
        logic [7:0]  tx;
    } sfe_user_s;
    typedef struct packed {
        sfe_host_e   st;
        logic [2:0]  div;
        logic        sclk;
        logic        cs_n;
        logic        hold_n;
        logic [7:0]  sh;
        logic [3:0]  bits;
        logic [1:0]  acnt;
        logic [7:0]  len;
        sfe_cmd_s    dec;
        logic [23:0] addr;
        logic [3:0]  lane;
        logic [3:0]  oe;
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic        busy;
        logic        take;
        logic        rxv;
        logic [7:0]  rxb;
    } sfe_host_s;

    function automatic sfe_cmd_s sfe_decode(input logic [7:0] c);
        sfe_cmd_s d;
        d = '0;
        d.has_addr = 1'b1;
        d.dev_out = 1'b1;
        d.aw = `SFE_W1;
        d.dw = `SFE_W1;
        case (c)
            `SFE_C_READ, `SFE_C_FAST: d.has_addr = 1'b1;
            `SFE_C_DOR: d.dw = `SFE_W2;
            `SFE_C_DIO, `SFE_C_DID: begin
                d.aw = `SFE_W2;
                d.dw = `SFE_W2;
            end
            `SFE_C_QOR: begin
                d.quad = 1'b1;
                d.dw = `SFE_W4;
            end
            `SFE_C_QIO, `SFE_C_QIOW, `SFE_C_QID: begin
                d.quad = 1'b1;
                d.aw = `SFE_W4;
                d.dw = `SFE_W4;
            end
            `SFE_C_QPP: begin
                d.dev_out = 1'b0;
                d.quad = 1'b1;
                d.dw = `SFE_W4;
            end
            `SFE_C_PP, `SFE_C_SE, `SFE_C_BE32, `SFE_C_BE64: d.dev_out = 1'b0;
            `SFE_C_RDSR, `SFE_C_RDID: d.has_addr = 1'b0;
            default: begin
                d.has_addr = 1'b0;
                d.dev_out = 1'b0;
            end
        endcase
        return d;
    endfunction

    // Lane 1 carries the high bit of each pair, lane 3 the high bit of each nibble
    function automatic logic [7:0] sfe_shift_in(input logic [7:0] s, input sfe_width_t w, input logic [3:0] l);
        return (s << w) | ({4'h0, l} & ((8'h01 << w) - 8'h01));
    endfunction
endpackage

// ==== include/sfe_if.sv ====
/*
 Pin bundle between the flash end and the host end.
 Assumes both ends drive only through their own data and enable vectors;
 an undriven lane reads high, as with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
interface sfe_if;
    logic       cs_n;
    logic       sclk;
    logic [3:0] h_d;
    logic [3:0] h_oe;
    logic [3:0] d_d;
    logic [3:0] d_oe;
    wire  [3:0] lane;
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_lane
            assign lane[i] = d_oe[i] ? d_d[i] : (h_oe[i] ? h_d[i] : 1'b1);
        end
    endgenerate
    modport dev (input cs_n, input sclk, input lane, output d_d, output d_oe);
    modport host (output cs_n, output sclk, output h_d, output h_oe, input lane);
endinterface
`default_nettype wire

// ==== hdl/sfe_host_end.sv ====
/*
 Host end: SPI mode 0 master that makes the serial clock by dividing clk_in
 by eight. Assumes the flash end on the other side of sfe_if.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sfe_consts.svh"
module sfe_host_end (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    sfe_if.host              lnk,
    input  wire logic        go_in,
    input  wire logic [7:0]  cmd_in,
    input  wire logic [23:0] addr_in,
    input  wire logic [7:0]  len_in,
    input  wire logic        pause_in,
    input  wire logic        quad_lane_enable_bit_in,
    input  wire logic [7:0]  tx_byte_in,
    output logic             busy_out,
    output logic             tx_take_out,
    output logic             rx_valid_out,
    output logic [7:0]       rx_byte_out
);
    import sfe_pkg::*;
    sfe_host_s  hq;
    sfe_host_s  hd;
    sfe_cmd_s   ndec;
    sfe_width_t w;
    sfe_width_t nw;
    logic [7:0] nsh;
    logic [3:0] nb;

    always_comb begin
        hd = hq;
        hd.s1 = lnk.lane;
        hd.s2 = hq.s1;
        hd.take = 1'b0;
        hd.rxv = 1'b0;
        ndec = sfe_decode(cmd_in);
        w = (hq.st == SFE_H_ADDR) ? hq.dec.aw : ((hq.st == SFE_H_DATA) ? hq.dec.dw : `SFE_W1);
        nsh = sfe_shift_in(hq.sh, w, (w == `SFE_W1) ? {3'h0, hq.s2[1]} : hq.s2);
        nb = hq.bits + {1'b0, w};
        case (hq.st)
            SFE_H_IDLE: begin
                hd.busy = 1'b0;
                // (RULE_06) quad command refused without the enable bit
                if (go_in && !(ndec.quad && !quad_lane_enable_bit_in)) begin
                    hd.dec = ndec;
                    hd.sh = cmd_in;
                    hd.addr = addr_in;
                    hd.len = len_in;
                    hd.bits = '0;
                    hd.acnt = '0;
                    hd.div = '0;
                    // (RULE_13) pause released before select
                    hd.hold_n = 1'b1;
                    hd.cs_n = 1'b0;
                    hd.busy = 1'b1;
                    hd.st = SFE_H_CMD;
                end
            end
            SFE_H_GAP: begin
                // (RULE_14) select driven high when idle
                hd.cs_n = 1'b1;
                hd.st = SFE_H_IDLE;
            end
            default: begin
                if (!hq.hold_n) begin
                    hd.hold_n = !pause_in;
                // (RULE_09) pause entered only with clock low
                end else if (pause_in && !quad_lane_enable_bit_in && !hq.sclk) begin
                    hd.hold_n = 1'b0;
                end else begin
                    hd.div = hq.div + 3'h1;
                    // (RULE_03) host data changes with falling clock
                    if (hq.div == `SFE_DIV_RISE) begin
                        hd.sclk = 1'b1;
                    end else if (hq.div == `SFE_DIV_FALL) begin
                        hd.sclk = 1'b0;
                        hd.sh = nsh;
                        hd.bits = (nb == `SFE_BYTE_BITS) ? 4'h0 : nb;
                        if (nb == `SFE_BYTE_BITS) begin
                            if (hq.st == SFE_H_CMD && hq.dec.has_addr) begin
                                hd.st = SFE_H_ADDR;
                                hd.sh = hq.addr[23:16];
                            end else if (hq.st == SFE_H_ADDR && hq.acnt != `SFE_ADDR_LAST) begin
                                hd.acnt = hq.acnt + 2'h1;
                                hd.sh = hq.addr[15:8];
                                hd.addr = {hq.addr[15:0], 8'h00};
                            end else begin
                                if (hq.st == SFE_H_DATA) begin
                                    hd.rxv = hq.dec.dev_out;
                                    hd.rxb = nsh;
                                    hd.len = hq.len - 8'h01;
                                end
                                hd.st = SFE_H_DATA;
                                if (hd.len == 8'h00) begin
                                    hd.st = SFE_H_GAP;
                                    hd.cs_n = 1'b1;
                                end else if (!hq.dec.dev_out) begin
                                    hd.sh = tx_byte_in;
                                    hd.take = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
        endcase
        nw = (hd.st == SFE_H_ADDR) ? hd.dec.aw : ((hd.st == SFE_H_DATA) ? hd.dec.dw : `SFE_W1);
        // (RULE_04) lanes and direction follow the phase width
        hd.oe = 4'hf;
        if (nw == `SFE_W4) begin
            hd.lane = hd.sh[7:4];
        end else if (nw == `SFE_W2) begin
            hd.lane = {hd.hold_n, 1'b1, hd.sh[7:6]};
        end else begin
            hd.lane = {hd.hold_n, 1'b1, 1'b0, hd.sh[7]};
            hd.oe = 4'hd;
        end
        if (hd.st == SFE_H_DATA && hd.dec.dev_out) begin
            hd.oe = (nw == `SFE_W1) ? 4'hd : ((nw == `SFE_W2) ? 4'hc : 4'h0);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hq <= '0;
            hq.cs_n <= 1'b1;
            hq.hold_n <= 1'b1;
            hq.lane <= 4'hc;
            hq.oe <= 4'hd;
        end else begin
            hq <= hd;
        end
    end

    assign lnk.cs_n = hq.cs_n;
    assign lnk.sclk = hq.sclk;
    assign lnk.h_d = hq.lane;
    assign lnk.h_oe = hq.oe;
    assign busy_out = hq.busy;
    assign tx_take_out = hq.take;
    assign rx_valid_out = hq.rxv;
    assign rx_byte_out = hq.rxb;
endmodule
`default_nettype wire

// ==== sim/sfe_link_assertions.sv ====
/* Checker of the link between the host and flash ends.
   Assumes the plain signals of sfe_if, sampled on clk_in. */
`timescale 1ns/100ps
`default_nettype none
module sfe_link_assertions (
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic [3:0] h_d,
    input wire logic [3:0] h_oe,
    input wire logic [3:0] d_d,
    input wire logic [3:0] d_oe,
    input wire logic [3:0] lane
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic       sclk_q;
    logic [9:0] rise_q;
    // Rising clock edges within the current frame
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sclk_q <= 1'b0;
            rise_q <= 10'h0;
        end else begin
            sclk_q <= sclk;
            rise_q <= cs_n ? 10'h0 : rise_q + {9'h0, sclk & ~sclk_q};
        end
    end
    AST_NO_FIGHT: assert property ((d_oe & h_oe) == 4'h0)
        else $error("both ends drive one lane");
    AST_DEV_LANES: assert property (d_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("device lane set not single, dual or quad");
    AST_SCLK_IDLE: assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("clock moves while deselected");
    AST_DEV_QUIET: assert property (cs_n && $past(cs_n) |-> d_oe == 4'h0)
        else $error("device drives while deselected");
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("clock high phase not four cycles");
    AST_HOST_STEADY: assert property (sclk && $past(sclk) |-> $stable(h_d))
        else $error("host lanes change while clock high");
    AST_DEV_STEADY: assert property (!cs_n && sclk && $past(sclk) |-> $stable(d_d) && $stable(d_oe))
        else $error("device lanes change while clock high");
    AST_LEAD: assert property ($fell(cs_n) |-> !sclk [*3])
        else $error("no low clock lead after select");
    AST_BITS: assert property ($rose(cs_n) |-> rise_q >= 10'h8 && !rise_q[0])
        else $error("frame clock count short or odd");
    AST_HOLD_IN: assert property (h_oe[3] && !d_oe[3] && $fell(lane[3]) |-> !sclk)
        else $error("hold lowered with clock high");
    cover property ($rose(cs_n));
    cover property (d_oe == 4'hf);
    cover property ((!cs_n && h_oe[3] && !lane[3] && !sclk) [*8]);
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
/* Bench: host and flash ends on lk; a bit-bang master on lk2 drives a
   second flash end. Assumes sfe_pkg, sfe_if and sfe_consts.svh. */
`timescale 1ns/100ps
`default_nettype none
`include "sfe_consts.svh"
module tb_top;
    import sfe_pkg::*;
    logic        clk_in, rstn_in, go, pause, qe, dld, bsy, tk, hv, fv, sel, f2v;
    logic [7:0]  cmd, len, htx, dtx, hrx, frx, f2rx, fcmd;
    logic [23:0] addr, fadr, fbas;
    sfe_phase_e  fk, f2k;
    logic [9:0]  ev[$], ev2[$];
    logic [7:0]  hq[$];
    logic [7:0]  cl[16] = '{`SFE_C_PP, `SFE_C_QPP, `SFE_C_SE, `SFE_C_BE32, `SFE_C_BE64, `SFE_C_READ,
        `SFE_C_FAST, `SFE_C_DOR, `SFE_C_QOR, `SFE_C_DIO, `SFE_C_QIO, `SFE_C_QIOW, `SFE_C_DID, `SFE_C_QID,
        `SFE_C_RDSR, `SFE_C_RDID};
    logic [7:0]  fr[4] = '{`SFE_C_SE, 8'h12, 8'h34, 8'h56};
    int          fails = 0;
    int          n_checks = 0;
    int          n, hdr;
    bit          inc, tkd;
    sfe_if lk ();
    sfe_if lk2 ();
    sfe_host_end sfe_host_end_i (.clk_in(clk_in), .rstn_in(rstn_in), .lnk(lk.host), .go_in(go), .cmd_in(cmd),
        .addr_in(addr), .len_in(len), .pause_in(pause), .quad_lane_enable_bit_in(qe), .tx_byte_in(htx),
        .busy_out(bsy), .tx_take_out(tk), .rx_valid_out(hv), .rx_byte_out(hrx));
    sfe_flash_end sfe_flash_end_i (.clk_in(clk_in), .rstn_in(rstn_in), .lnk(lk.dev), .quad_lane_enable_bit_in(qe),
        .tx_load_in(dld), .tx_byte_in(dtx), .sel_out(sel), .rx_valid_out(fv), .rx_kind_out(fk),
        .rx_byte_out(frx), .cmd_out(fcmd), .addr_out(fadr), .erase_base_out(fbas));
    sfe_flash_end sfe_flash_end_2_i (.clk_in(clk_in), .rstn_in(rstn_in), .lnk(lk2.dev),
        .quad_lane_enable_bit_in(1'b0), .tx_load_in(1'b0), .tx_byte_in(8'h00), .sel_out(), .rx_valid_out(f2v),
        .rx_kind_out(f2k), .rx_byte_out(f2rx), .cmd_out(), .addr_out(), .erase_base_out());
    sfe_link_assertions sfe_link_assertions_i (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n(lk.cs_n),
        .sclk(lk.sclk), .h_d(lk.h_d), .h_oe(lk.h_oe), .d_d(lk.d_d), .d_oe(lk.d_oe), .lane(lk.lane));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // Byte k+1 loads once byte k has begun: events lead the next byte start by one cycle
    always @(posedge clk_in) begin : cap
        #1;
        dtx = dtx + {7'h0, inc};
        htx = htx + {7'h0, tkd};
        dld = sel !== 1'b1 || inc;
        if (fv === 1'b1) ev.push_back({fk, frx});
        if (f2v === 1'b1) ev2.push_back({f2k, f2rx});
        if (hv === 1'b1) hq.push_back(hrx);
        inc = fv === 1'b1 && ev.size() >= hdr;
        tkd = tk === 1'b1;
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Mode 3 byte on lk2: clock idles high, 32 ns period
    task automatic bb(input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            lk2.sclk = 1'b0;
            lk2.h_d[0] = b[k];
            #16;
            lk2.sclk = 1'b1;
            #16;
        end
    endtask
    task automatic p2(input logic c, input logic s, input logic h);
        lk2.cs_n = c;
        lk2.sclk = s;
        lk2.h_d[3] = h;
        #16;
    endtask
    task automatic xfer(input logic [7:0] c, input logic [23:0] a, input bit p);
        logic [7:0]  h0, d0;
        logic [23:0] m;
        bit          rd, na;
        int          i;
        h0 = htx;
        d0 = dtx;
        rd = !(c inside {`SFE_C_PP, `SFE_C_QPP, `SFE_C_SE, `SFE_C_BE32, `SFE_C_BE64});
        na = c inside {`SFE_C_RDSR, `SFE_C_RDID};
        hdr = na ? 1 : 4;
        len = c inside {`SFE_C_SE, `SFE_C_BE32, `SFE_C_BE64} ? 8'h0 : 8'h2;
        m = c == `SFE_C_SE ? `SFE_SECT_MASK : c == `SFE_C_BE32 ? `SFE_B32_MASK :
            c == `SFE_C_BE64 ? `SFE_B64_MASK : `SFE_PAGE_MASK;
        ev.delete();
        hq.delete();
        cmd = c;
        addr = a;
        go = 1'b1;
        for (i = 0; i < 20 && bsy !== 1'b1; i++) cyc(1);
        go = 1'b0;
        if (p) begin
            cyc(40);
            pause = 1'b1;
            cyc(30);
            chk("sel", 1, sel);
            pause = 1'b0;
        end
        for (i = 0; i < 3000 && bsy !== 1'b0; i++) cyc(1);
        cyc(10);
        chk("events", hdr + len, ev.size());
        chk("cmd event", {SFE_PH_CMD, c}, ev[0]);
        chk("cmd_out", c, fcmd);
        for (i = 1; i < hdr + len; i++) begin
            if (i < 4 && !na) chk("addr byte", {SFE_PH_ADDR, a[8*(3-i)+:8]}, ev[i]);
            else if (rd) chk("data kind", SFE_PH_DATA, ev[i][9:8]);
            else chk("write byte", {SFE_PH_DATA, 8'(h0 + i - 4)}, ev[i]);
        end
        chk("rx count", rd ? len : 8'h0, hq.size());
        for (i = 0; i < len && rd && !na; i++) chk("read byte", 8'(d0 + i), hq[i]);
        if (!na) chk("addr", a & `SFE_ARRAY_MASK, fadr);
        if (!na) chk("base", a & `SFE_ARRAY_MASK & m, fbas);
    endtask
    initial begin
        cyc(40000);
        fails++;
        print_verdict();
    end
    initial begin
        {rstn_in, go, pause, qe, dld, cmd, len, addr} = '0;
        htx = 8'h5a;
        dtx = 8'ha0;
        lk2.h_d = 4'hf;
        lk2.h_oe = 4'hd;
        p2(1, 1, 1);
        cyc(16);
        rstn_in = 1'b1;
        cyc(2);
        xfer(`SFE_C_READ, 24'hffffff, 1'b1);
        cmd = `SFE_C_QOR;
        go = 1'b1;
        cyc(20);
        chk("quad refused", 0, bsy);
        go = 1'b0;
        // cl[0] is plain while the enable bit syncs
        qe = 1'b1;
        foreach (cl[i]) xfer(cl[i], 24'(24'h93c5e7 + 24'h1d0b31 * i), 1'b0);
        p2(0, 1, 1);
        bb(`SFE_C_RDSR);
        p2(0, 0, 1);
        chk("oe single", 4'h2, lk2.d_oe);
        p2(0, 0, 0);
        bb(8'h00);
        p2(0, 0, 0);
        chk("oe paused", 4'h0, lk2.d_oe);
        p2(1, 0, 0);
        p2(1, 1, 1);
        p2(0, 1, 1);
        bb(`SFE_C_QOR);
        bb(8'h12);
        chk("oe refused", 4'h0, lk2.d_oe);
        p2(1, 1, 1);
        p2(0, 1, 1);
        foreach (fr[i]) bb(fr[i]);
        lk2.cs_n = 1'b1;
        cyc(12);
        chk("first cmd", {SFE_PH_CMD, `SFE_C_RDSR}, ev2[0]);
        chk("erase cmd", {SFE_PH_CMD, `SFE_C_SE}, ev2[ev2.size() - 4]);
        chk("last addr", {SFE_PH_ADDR, 8'h56}, ev2[ev2.size() - 1]);
        n = 0;
        foreach (ev2[i]) n += (ev2[i][9:8] !== 2'b00);
        chk("non-cmd events", 3, n);
        print_verdict();
    end
endmodule
`default_nettype wire
